// file: ivp_pkg.sv
// Package with vector offsets, source indices, levels and priority order for the interrupt vector block
package ivp_pkg;
  // Widths, counts, nonmaskable level and offset step and limit
  localparam int IVP_ADDR_W    = 24;
  localparam int IVP_NSRC      = 48;
  localparam int IVP_SRC_W     = 6;
  localparam int IVP_LVL_W     = 2;
  localparam int IVP_OFS_W     = 8;
  localparam logic [1:0] IVP_LVL_NMI = 2'h3;
  localparam logic [7:0] IVP_OFS_STEP = 8'h02;
  localparam logic [7:0] IVP_OFS_MAX  = 8'hFE;
  localparam int IVP_NNMI      = 6;

  // Source indices, in fixed service order (index 0 is served first)
  localparam int IVP_S_RESET   = 0;
  localparam int IVP_S_STKERR  = 1;
  localparam int IVP_S_ILLEGAL = 2;
  localparam int IVP_S_DEBUG   = 3;
  localparam int IVP_S_TRAP    = 4;
  localparam int IVP_S_NMI_PIN = 5;
  localparam int IVP_S_EXT_A   = 6;
  localparam int IVP_S_DMA0    = 10;
  localparam int IVP_S_HOST_CMD = 16;
  localparam int IVP_S_HOST_TXE = 17;
  localparam int IVP_S_HOST_RXF = 18;
  localparam int IVP_S_SSP0    = 19;
  localparam int IVP_S_SSP1    = 25;
  localparam int IVP_S_ASP     = 31;
  localparam int IVP_S_TMR     = 36;

  // Vector offset of each source, indexed by service order
  localparam logic [7:0] IVP_OFS_TABLE [IVP_NSRC] = '{
    8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
    8'h10, 8'h12, 8'h14, 8'h16,
    8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
    8'h64, 8'h62, 8'h60,
    8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36,
    8'h42, 8'h40, 8'h44, 8'h48, 8'h4A, 8'h46,
    8'h52, 8'h50, 8'h54, 8'h56, 8'h58,
    8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E, 8'h2C,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };
  localparam int IVP_NUSED = 42;
endpackage

// file: ivp_offset_rom.sv
// Registered lookup from source index to its vector offset
module ivp_offset_rom
  import ivp_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // Lookup
  input  wire logic [IVP_SRC_W-1:0] i_src,
  output logic      [IVP_OFS_W-1:0] o_ofs
);
  // Offset register, reset to the reset vector slot
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_ofs <= 8'h00;
    end else if (int'(i_src) < IVP_NUSED) begin
      o_ofs <= IVP_OFS_TABLE[i_src];
    end else begin
      o_ofs <= 8'h00;
    end
  end
endmodule // ivp_offset_rom

// file: ivp_interrupt_vector_priority.sv
// Interrupt arbitration and vector address generation for the core
// What this block does
// - Vector is base plus even two-word offset
// - Level 3 sources served reset first
// - Maskable levels 0-2, external pins first
// - DMA channels 18-22, after external pins
// - Host 60/62/64, command first after DMA5
// - Sync port 0 at 30-3A, 3C/3E reserved
// - Sync port 0 order after host requests
// - Sync port 1 at 40-4A, same layout
// - Sync port 1 ranks after port 0
// - Async port 50-58, 5A-5E reserved
// - Async then timers, overflow before compare
module ivp_interrupt_vector_priority
  import ivp_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_srst,
  // Vector base and core mask
  input  wire logic [IVP_ADDR_W-1:0] i_vector_base_address,
  input  wire logic [IVP_LVL_W-1:0]  i_core_mask,
  // Nonmaskable requests
  input  wire logic                  i_hw_reset_req,
  input  wire logic                  i_stack_error,
  input  wire logic                  i_illegal_instr,
  input  wire logic                  i_debug_req,
  input  wire logic                  i_trap,
  input  wire logic                  i_nmi_pin,
  // External pins A..D
  input  wire logic [3:0]            i_ext_request,
  input  wire logic [3:0][1:0]       i_ext_level,
  // DMA channels 0..5
  input  wire logic [5:0]            i_dma_req,
  input  wire logic [1:0]            i_dma_level,
  // Timers: one compare bit and one overflow bit per timer, bit k for timer k
  input  wire logic [2:0]            i_tmr_compare,
  input  wire logic [2:0]            i_tmr_overflow,
  input  wire logic [1:0]            i_tmr_level,
  // Sync serial ports: rx, rx_exc, rx_last, tx, tx_exc, tx_last
  input  wire logic [5:0]            i_sync_serial_port_0,
  input  wire logic [1:0]            i_ssp0_level,
  input  wire logic [5:0]            i_sync_serial_port_1,
  input  wire logic [1:0]            i_ssp1_level,
  // Async port: rx, rx_exc, tx, idle, timer
  input  wire logic [4:0]            i_async_serial_port,
  input  wire logic [1:0]            i_asp_level,
  // Host port: rx_full, tx_empty, command
  input  wire logic [2:0]            i_host_req,
  input  wire logic [1:0]            i_host_level,
  // Offer to the core
  output logic                       o_irq_valid,
  output logic [IVP_LVL_W-1:0]       o_irq_level,
  output logic [IVP_SRC_W-1:0]       o_irq_source,
  output logic [IVP_ADDR_W-1:0]      o_irq_vector
);
  logic [IVP_NSRC-1:0]      req;
  logic [1:0]               lvl [IVP_NSRC];
  logic [IVP_NSRC-1:0]      elig;
  logic                     any;
  logic [IVP_LVL_W-1:0]     best_lvl;
  logic [IVP_SRC_W-1:0]     best_src;
  logic [IVP_OFS_W-1:0]     rom_ofs;
  logic                     next_valid;
  logic                     valid_d;
  logic [IVP_LVL_W-1:0]     lvl_d;
  logic [IVP_SRC_W-1:0]     src_d;

  // Gather requests into the fixed service order
  always_comb begin
    req = '0;
    for (int k = 0; k < IVP_NSRC; k++) lvl[k] = 2'h0;
    req[IVP_S_RESET]   = i_hw_reset_req;
    req[IVP_S_STKERR]  = i_stack_error;
    req[IVP_S_ILLEGAL] = i_illegal_instr;
    req[IVP_S_DEBUG]   = i_debug_req;
    req[IVP_S_TRAP]    = i_trap;
    req[IVP_S_NMI_PIN] = i_nmi_pin;
    for (int k = 0; k < IVP_NNMI; k++) lvl[k] = IVP_LVL_NMI;
    for (int k = 0; k < 4; k++) begin
      req[IVP_S_EXT_A+k] = i_ext_request[k];
      lvl[IVP_S_EXT_A+k] = i_ext_level[k];
    end
    for (int k = 0; k < 6; k++) begin
      req[IVP_S_DMA0+k] = i_dma_req[k];
      lvl[IVP_S_DMA0+k] = i_dma_level;
    end
    // Host: command, tx empty, rx full
    req[IVP_S_HOST_CMD] = i_host_req[2];
    req[IVP_S_HOST_TXE] = i_host_req[1];
    req[IVP_S_HOST_RXF] = i_host_req[0];
    for (int k = 0; k < 3; k++) lvl[IVP_S_HOST_CMD+k] = i_host_level;
    // Sync port order: rx_exc, rx, rx_last, tx_exc, tx_last, tx
    req[IVP_S_SSP0+0] = i_sync_serial_port_0[1];
    req[IVP_S_SSP0+1] = i_sync_serial_port_0[0];
    req[IVP_S_SSP0+2] = i_sync_serial_port_0[2];
    req[IVP_S_SSP0+3] = i_sync_serial_port_0[4];
    req[IVP_S_SSP0+4] = i_sync_serial_port_0[5];
    req[IVP_S_SSP0+5] = i_sync_serial_port_0[3];
    req[IVP_S_SSP1+0] = i_sync_serial_port_1[1];
    req[IVP_S_SSP1+1] = i_sync_serial_port_1[0];
    req[IVP_S_SSP1+2] = i_sync_serial_port_1[2];
    req[IVP_S_SSP1+3] = i_sync_serial_port_1[4];
    req[IVP_S_SSP1+4] = i_sync_serial_port_1[5];
    req[IVP_S_SSP1+5] = i_sync_serial_port_1[3];
    for (int k = 0; k < 6; k++) begin
      lvl[IVP_S_SSP0+k] = i_ssp0_level;
      lvl[IVP_S_SSP1+k] = i_ssp1_level;
    end
    // Async order: rx_exc, rx, tx, idle, timer
    req[IVP_S_ASP+0] = i_async_serial_port[1];
    req[IVP_S_ASP+1] = i_async_serial_port[0];
    req[IVP_S_ASP+2] = i_async_serial_port[2];
    req[IVP_S_ASP+3] = i_async_serial_port[3];
    req[IVP_S_ASP+4] = i_async_serial_port[4];
    for (int k = 0; k < 5; k++) lvl[IVP_S_ASP+k] = i_asp_level;
    // Timers: overflow before compare
    for (int k = 0; k < 3; k++) begin
      req[IVP_S_TMR+2*k]   = i_tmr_overflow[k];
      req[IVP_S_TMR+2*k+1] = i_tmr_compare[k];
      lvl[IVP_S_TMR+2*k]   = i_tmr_level;
      lvl[IVP_S_TMR+2*k+1] = i_tmr_level;
    end
    // Maskable levels run 0..2 only; a level of 3 is clamped to 2
    for (int k = IVP_NNMI; k < IVP_NUSED; k++) begin
      if (lvl[k] == IVP_LVL_NMI) lvl[k] = 2'h2;
    end
  end

  // Eligibility: nonmaskable always, maskable above core mask
  always_comb begin
    for (int k = 0; k < IVP_NSRC; k++) begin
      elig[k] = req[k] && ((k < IVP_NNMI) || (lvl[k] > i_core_mask));
    end
  end

  // Highest level first, then lowest index in the fixed order
  always_comb begin
    any      = 1'b0;
    best_lvl = 2'h0;
    best_src = '0;
    for (int k = 0; k < IVP_NUSED; k++) begin
      if (elig[k] && (!any || (lvl[k] > best_lvl))) begin
        any      = 1'b1;
        best_lvl = lvl[k];
        best_src = IVP_SRC_W'(k);
      end
    end
  end

  assign next_valid = any;

  // Vector offset lookup, reserved slots never appear in the table
  ivp_offset_rom u_rom (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_src     (best_src),
    .o_ofs     (rom_ofs)
  );

  // Pipeline the choice to match the offset register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      valid_d <= 1'b0;
      lvl_d   <= 2'h0;
      src_d   <= '0;
    end else begin
      valid_d <= next_valid;
      lvl_d   <= best_lvl;
      src_d   <= best_src;
    end
  end

  // Vector address is base plus offset
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_irq_valid  <= 1'b0;
      o_irq_level  <= 2'h0;
      o_irq_source <= '0;
      o_irq_vector <= '0;
    end else begin
      o_irq_valid  <= valid_d;
      o_irq_level  <= lvl_d;
      o_irq_source <= src_d;
      // Idle offer shows a zero vector, so nothing stale reaches the core
      o_irq_vector <= valid_d ? (i_vector_base_address + IVP_ADDR_W'(rom_ofs)) : '0;
    end
  end
endmodule // ivp_interrupt_vector_priority

// file: ivp_interrupt_vector_priority_properties.sv
// Concurrent checks on the offer made by the interrupt vector priority block
module ivp_interrupt_vector_priority_properties
  import ivp_pkg::*;
(
  // Clock, reset and inputs watched
  input wire logic                  i_clk_sys,
  input wire logic                  i_srst,
  input wire logic [IVP_ADDR_W-1:0] i_vector_base_address,
  input wire logic [IVP_LVL_W-1:0]  i_core_mask,
  input wire logic                  i_hw_reset_req,
  input wire logic                  i_nmi_pin,
  input wire logic [3:0]            i_ext_request,
  input wire logic [3:0][1:0]       i_ext_level,
  // Offer to the core
  input wire logic                  o_irq_valid,
  input wire logic [IVP_LVL_W-1:0]  o_irq_level,
  input wire logic [IVP_SRC_W-1:0]  o_irq_source,
  input wire logic [IVP_ADDR_W-1:0] o_irq_vector
);
  logic rst_d1;
  logic rst_d2;
  logic ext_a_d1;
  logic ext_a_d2;
  // Pipeline of reset and of a level 2 pin A request that the core mask allows
  always_ff @(posedge i_clk_sys) begin
    rst_d1   <= i_srst;
    rst_d2   <= rst_d1;
    ext_a_d1 <= i_ext_request[0] && i_ext_level[0][1] && !i_core_mask[1];
    ext_a_d2 <= ext_a_d1;
  end
  // History is trusted only two edges after reset
  wire settled = !rst_d1 && !rst_d2;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  AST_RESET_QUIET: assert property (rst_d1 |-> !o_irq_valid && o_irq_source == 6'h00)
    else $error("offer not cleared after reset");
  AST_NMI_TOP: assert property (settled && $past(i_nmi_pin, 2) |-> o_irq_valid && o_irq_level == 2'h3)
    else $error("nonmaskable request not offered at level 3");
  AST_RESET_SLOT: assert property (settled && $past(i_hw_reset_req, 2)
    |-> o_irq_source == 6'h00 && o_irq_vector == $past(i_vector_base_address))
    else $error("reset request not served first at the base");
  AST_EVEN_OFS: assert property (settled && o_irq_valid
    |-> ((o_irq_vector - $past(i_vector_base_address)) & 24'hFFFF01) == 24'h000000)
    else $error("vector offset odd or beyond FE");
  AST_ABOVE_MASK: assert property (settled && o_irq_valid && o_irq_level != 2'h3
    |-> o_irq_level > $past(i_core_mask, 2))
    else $error("maskable offer not above core mask");
  AST_EXT_A_FIRST: assert property (settled && ext_a_d2 && o_irq_level != 2'h3
    |-> o_irq_source == 6'h06 && o_irq_level == 2'h2)
    else $error("pin A did not win its level");
  AST_DMA0_SLOT: assert property (settled && o_irq_valid && o_irq_source == 6'h0A
    |-> o_irq_vector == $past(i_vector_base_address) + 24'h000018)
    else $error("channel 0 vector wrong");
  AST_TMR0_OVF: assert property (settled && o_irq_valid && o_irq_source == 6'h24
    |-> o_irq_vector == $past(i_vector_base_address) + 24'h000026)
    else $error("timer 0 overflow vector wrong");
endmodule // ivp_interrupt_vector_priority_properties

bind ivp_interrupt_vector_priority ivp_interrupt_vector_priority_properties ivp_props_inst (.i_clk_sys, .i_srst,
  .i_vector_base_address, .i_core_mask, .i_hw_reset_req, .i_nmi_pin, .i_ext_request, .i_ext_level,
  .o_irq_valid, .o_irq_level, .o_irq_source, .o_irq_vector);

// file: ivp_core_model.sv
// Behavioural core that holds the interrupt mask and counts cycles with an offer pending
module ivp_core_model
  import ivp_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // Mask wanted by the bench, offer seen
  input  wire logic [IVP_LVL_W-1:0] i_mask_set,
  input  wire logic                 i_irq_valid,
  output logic      [IVP_LVL_W-1:0] o_core_mask,
  output int                        o_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mask follows the running program at once
  assign o_core_mask = i_mask_set;
  // Count cycles with an offer pending
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_taken <= 0;
    else if (i_irq_valid) o_taken <= o_taken + 1;
  end
endmodule // ivp_core_model

// file: ivp_interrupt_vector_priority_tb.sv
// Self-checking bench for the interrupt vector priority block
module ivp_interrupt_vector_priority_tb;
  import ivp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin error_cnt++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
  logic i_clk_sys = 0, i_srst = 1;
  logic [23:0] base = 0, o_vec;
  logic [1:0] mask_set = 0, core_mask, o_lvl, lv [10];
  logic [41:0] req = 0;
  logic o_valid;
  logic [5:0] o_src;
  logic [32:0] q [$], e;
  int error_cnt = 0, checks = 0, seed = 32'h8d10;
  event ev;
  // Offsets of each source in service order
  logic [7:0] ofs [42] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A,
    8'h1C, 8'h1E, 8'h20, 8'h22, 8'h64, 8'h62, 8'h60, 8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36, 8'h42, 8'h40,
    8'h44, 8'h48, 8'h4A, 8'h46, 8'h52, 8'h50, 8'h54, 8'h56, 8'h58, 8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E, 8'h2C};
  always #4 i_clk_sys = ~i_clk_sys;
  ivp_core_model ivp_core_model_inst (.i_clk_sys, .i_srst, .i_mask_set(mask_set), .i_irq_valid(o_valid),
    .o_core_mask(core_mask), .o_taken());
  ivp_interrupt_vector_priority ivp_interrupt_vector_priority_inst (.i_clk_sys, .i_srst,
    .i_vector_base_address(base), .i_core_mask(core_mask), .i_hw_reset_req(req[0]), .i_stack_error(req[1]),
    .i_illegal_instr(req[2]), .i_debug_req(req[3]), .i_trap(req[4]), .i_nmi_pin(req[5]),
    .i_ext_request(req[9:6]), .i_ext_level({lv[3], lv[2], lv[1], lv[0]}), .i_dma_req(req[15:10]),
    .i_dma_level(lv[4]), .i_tmr_compare({req[41], req[39], req[37]}),
    .i_tmr_overflow({req[40], req[38], req[36]}), .i_tmr_level(lv[9]),
    .i_sync_serial_port_0({req[23], req[22], req[24], req[21], req[19], req[20]}), .i_ssp0_level(lv[6]),
    .i_sync_serial_port_1({req[29], req[28], req[30], req[27], req[25], req[26]}), .i_ssp1_level(lv[7]),
    .i_async_serial_port({req[35], req[34], req[33], req[31], req[32]}), .i_asp_level(lv[8]),
    .i_host_req({req[16], req[17], req[18]}), .i_host_level(lv[5]), .o_irq_valid(o_valid),
    .o_irq_level(o_lvl), .o_irq_source(o_src), .o_irq_vector(o_vec));
  // Level group of a maskable source
  function automatic int grp(int i);
    return (i < 6) ? 0 : (i < 10) ? i - 6 : (i < 16) ? 4 : (i < 19) ? 5 : (i < 25) ? 6 : (i < 31) ? 7 : (i < 36) ? 8 : 9;
  endfunction
  // Note the expected winner, drive the requests and hold them
  task automatic apply(input logic [41:0] r);
    int best;
    logic [1:0] bl, l;
    best = -1;
    bl = 0;
    for (int i = 0; i < 42; i++) begin
      l = (i < 6) ? 2'h3 : (lv[grp(i)] == 2'h3) ? 2'h2 : lv[grp(i)];
      if (r[i] && (i < 6 || l > mask_set) && (best < 0 || l > bl)) begin
        best = i;
        bl = l;
      end
    end
    q.push_back((best < 0 || i_srst) ? 33'h0 : {1'b1, bl, 6'(best), base + 24'(ofs[best])});
    req = r;
    repeat (3) @(posedge i_clk_sys);
    #1 ->ev;
  endtask
  // Compare the offer with the oldest note
  always @(ev) begin
    e = q.pop_front();
    `CHK("valid", e[32], o_valid)
    `CHK("level", e[31:30], o_lvl)
    `CHK("source", e[29:24], o_src)
    `CHK("vector", e[23:0], o_vec)
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    foreach (lv[k]) lv[k] = 2'h1;
    repeat (12) @(posedge i_clk_sys);
    #1 i_srst = 0;
    for (int i = 0; i < 42; i++) begin
      base = $random(seed);
      apply(42'h1 << i);
      apply(~((42'h1 << i) - 42'h1));
    end
    $display("test single and chained sources done");
    i_srst = 1;
    apply({42{1'b1}});
    i_srst = 0;
    apply(42'h0);
    for (int n = 0; n < 400; n++) begin
      foreach (lv[k]) lv[k] = $random(seed);
      mask_set = $random(seed);
      base = $random(seed);
      apply(42'({$random(seed), $random(seed)} & {$random(seed), $random(seed)} & {$random(seed), $random(seed)}));
    end
    $display("test random mixes done");
    test_done();
  end
  // Cut a hang short
  initial begin
    #200us error_cnt++;
    test_done();
  end
endmodule // ivp_interrupt_vector_priority_tb
